// ==== core/mssa_map.vh ====
// Constants for the multichannel sensor scan and alarm block
`ifndef MSSA_MAP_VH
`define MSSA_MAP_VH
`define MSSA_KIND_W 8
`define MSSA_KIND_DEFAULT 8'h00
`define MSSA_KIND_DISABLED 8'hFF
`define MSSA_KIND_MAX_SUPPORTED 8'h0F
`define MSSA_DATA_W 16
`define MSSA_DATA_OPEN_HIGH 16'h7FFF
`define MSSA_DATA_OPEN_LOW 16'h8001
`define MSSA_WEIGHT_W 8
`define MSSA_WEIGHT_RESET 8'h00
`define MSSA_FAIL_RESET 1'b1
`define MSSA_SLOT_NS 1000
`define MSSA_CLK_NS 8
`define MSSA_SLOT_CYCLES (`MSSA_SLOT_NS / `MSSA_CLK_NS)
`define MSSA_ALM_DISABLED 3'b001
`define MSSA_ALM_ARMED 3'b010
`define MSSA_ALM_SOUNDING 3'b100
`endif

// ==== core/mssa_smooth.v ====
// Single-pole low-pass filter datapath for one sample
`timescale 1ns/100ps
`include "mssa_map.vh"
module mssa_smooth #(
    parameter DW = 16,
    parameter KW = 8
) (
    input wire [DW-1:0] raw_sample,
    input wire [DW-1:0] prev_out,
    input wire [KW-1:0] weight,
    output wire [DW-1:0] filt_out
);
    wire signed [DW+KW+1:0] raw_term;
    wire signed [DW+KW+1:0] prev_term;
    wire signed [DW+KW+1:0] sum;
    // out = ((256-k)*raw + k*prev) / 256
    assign raw_term = $signed(raw_sample) * $signed({2'b00, (9'h100 - {1'b0, weight})});
    assign prev_term = $signed(prev_out) * $signed({2'b00, 1'b0, weight});
    assign sum = raw_term + prev_term;
    assign filt_out = sum[DW+KW-1:KW];
endmodule

// ==== core/mssa_alarm.v ====
// Alarm state machine for one channel
`timescale 1ns/100ps
`include "mssa_map.vh"
module mssa_alarm #(
    parameter DW = 16
) (
    input wire clk_sys,
    input wire reset_n,
    input wire clk_en,
    input wire arm_cmd,
    input wire arm_value,
    input wire kind_cmd,
    input wire alarm_read,
    input wire sample_valid,
    input wire [DW-1:0] data_value,
    input wire [DW-1:0] upper_threshold,
    input wire [DW-1:0] lower_threshold,
    output wire sounding,
    output wire armed
);
    reg [2:0] state_q;
    reg [2:0] state_d;
    wire violation;
    assign violation = ($signed(data_value) > $signed(upper_threshold)) ||
                       ($signed(data_value) < $signed(lower_threshold));
    assign sounding = state_q[2];
    assign armed = state_q[1];
    always @*
    begin
        state_d = state_q;
        case (state_q)
            `MSSA_ALM_DISABLED:
                if (arm_cmd && arm_value)
                    state_d = `MSSA_ALM_ARMED;
            `MSSA_ALM_ARMED:
                if (arm_cmd && !arm_value)
                    state_d = `MSSA_ALM_DISABLED;
                else if (sample_valid && violation)
                    state_d = `MSSA_ALM_SOUNDING;
                else if (!($signed(upper_threshold) > $signed(lower_threshold)))
                    state_d = `MSSA_ALM_SOUNDING;
            `MSSA_ALM_SOUNDING:
                if (alarm_read)
                    state_d = `MSSA_ALM_DISABLED;
            default:
                state_d = `MSSA_ALM_DISABLED;
        endcase
        if (kind_cmd)
            state_d = `MSSA_ALM_DISABLED;
    end
    always @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
            state_q <= `MSSA_ALM_DISABLED;
        else if (clk_en)
            state_q <= state_d;
    end
endmodule

// ==== core/mssa_scan_top.v ====
// Scan manager: sensor kinds, filtering, open-sensor handling, alarms
// Overview of operation
// - Declared sensor kind selects excitation, gain and curve for later scans.
// - Declaring a kind zeros channel data; fresh data within ten/nineteen slots.
// - Declaring a kind zeros the channel smoothing weight, bypassing the filter.
// - Declaring a kind disables the alarm; limits become undefined.
// - Reset sets every kind to the default five volt range, data zero.
// - An unsupported kind code selects the default kind.
// - Disabled-kind channels are skipped by the scan.
// - Weight 0..255; out = (1-k/256)*raw + (k/256)*previous out.
// - Reset clears every smoothing weight to zero.
// - Open sensor forces data to large positive if fail_positive, else negative.
// - After reset every channel fails positive.
// - Single read returns latest channel data; disabled kind gives undefined.
// - All-channel read returns every channel, disabled ones undefined.
// - One alarm per channel; condition is data above upper or below lower.
// - Alarms start Disabled; arm command moves between Disabled and Armed.
// - Violation while Armed enters Sounding and raises the board alarm flag.
// - Sounding holds until the alarm status read, which returns it to Disabled.
// - Upper not above lower makes an armed channel sound at once.
// - Limits are undefined after reset.
// - Junction temperature read returns termination board reading, else undefined.
// - After reset every alarm is disabled.
// - Status read gives per-channel sounding plus summary, clears sounding channels.
`timescale 1ns/100ps
`include "mssa_map.vh"
module mssa_scan_top #(
    parameter NCH = 8,
    parameter CW = 3,
    parameter DW = `MSSA_DATA_W,
    parameter SLOT_CYCLES = `MSSA_SLOT_CYCLES
) (
    input wire clk_sys,
    input wire reset_n,
    input wire clk_en,
    input wire declare_sensor_kind,
    input wire [CW-1:0] cmd_channel,
    input wire [`MSSA_KIND_W-1:0] sensor_kind_code,
    input wire set_smoothing,
    input wire [`MSSA_WEIGHT_W-1:0] smoothing_weight,
    input wire set_open_sensor_direction,
    input wire fail_positive,
    input wire set_limit_pair,
    input wire [DW-1:0] upper_threshold,
    input wire [DW-1:0] lower_threshold,
    input wire arm_or_disarm_limit,
    input wire arm_value,
    input wire read_one_channel,
    input wire read_every_channel,
    input wire read_junction_temperature,
    input wire read_and_clear_alarm_states,
    input wire [DW-1:0] adc_sample,
    input wire adc_open_sensor,
    input wire adc_done,
    input wire [DW-1:0] junction_temp_pin,
    output reg [CW-1:0] scan_channel,
    output reg [`MSSA_KIND_W-1:0] scan_kind,
    output reg scan_start,
    output reg [DW-1:0] read_data,
    output reg read_valid,
    output reg [NCH*DW-1:0] all_data,
    output reg [NCH-1:0] alarm_status,
    output reg alarm_summary,
    output wire board_alarm
);
    reg [`MSSA_KIND_W-1:0] kind_q [0:NCH-1];
    reg [`MSSA_WEIGHT_W-1:0] weight_q [0:NCH-1];
    reg [DW-1:0] data_q [0:NCH-1];
    reg [DW-1:0] upper_q [0:NCH-1];
    reg [DW-1:0] lower_q [0:NCH-1];
    reg [NCH-1:0] fail_pos_q;
    reg [15:0] slot_cnt_q;
    reg [DW-1:0] jt_meta_q;
    reg [DW-1:0] jt_sync_q;
    reg [DW-1:0] sample_q;
    reg open_q;
    reg done_meta_q;
    reg done_sync_q;
    reg done_prev_q;
    reg [DW-1:0] sample_meta_q;
    reg open_meta_q;
    reg store_q;
    reg [DW-1:0] jt_prev_q;
    reg [DW-1:0] jt_val_q;
    // Set once a channel holds a converted value
    reg [NCH-1:0] fresh_q;
    reg [CW-1:0] next_ch;
    reg [31:0] cand;
    reg found;
    wire [NCH-1:0] sounding;
    wire [NCH-1:0] enabled;
    wire done_rise;
    wire [DW-1:0] filt_out;
    wire [DW-1:0] stored_value;
    wire [`MSSA_KIND_W-1:0] kind_eff;
    integer i;
    integer j;
    genvar g;

    // Unsupported codes fall back to the default kind
    assign kind_eff = (sensor_kind_code == `MSSA_KIND_DISABLED ||
                       sensor_kind_code <= `MSSA_KIND_MAX_SUPPORTED) ?
                      sensor_kind_code : `MSSA_KIND_DEFAULT;
    assign board_alarm = |sounding;
    assign done_rise = done_sync_q && !done_prev_q;

    // Samples come back from the converter after the scan slot is launched
    always @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            done_meta_q <= 1'b0;
            done_sync_q <= 1'b0;
            done_prev_q <= 1'b0;
            jt_meta_q <= {DW{1'b0}};
            jt_sync_q <= {DW{1'b0}};
            jt_prev_q <= {DW{1'b0}};
            jt_val_q <= {DW{1'b0}};
            sample_meta_q <= {DW{1'b0}};
            open_meta_q <= 1'b0;
            sample_q <= {DW{1'b0}};
            open_q <= 1'b0;
            store_q <= 1'b0;
        end
        else if (clk_en)
        begin
            done_meta_q <= adc_done;
            done_sync_q <= done_meta_q;
            done_prev_q <= done_sync_q;
            jt_meta_q <= junction_temp_pin;
            jt_sync_q <= jt_meta_q;
            jt_prev_q <= jt_sync_q;
            // A word caught mid-change never matches its successor, so it is dropped
            if (jt_sync_q == jt_prev_q)
                jt_val_q <= jt_sync_q;
            sample_meta_q <= adc_sample;
            open_meta_q <= adc_open_sensor;
            // Sample bus is steady well before done rises, so the late copy is clean
            store_q <= done_rise;
            if (done_rise)
            begin
                sample_q <= sample_meta_q;
                open_q <= open_meta_q;
            end
        end
    end

    // Next enabled channel above the current one, wrapping to the lowest
    always @*
    begin
        next_ch = scan_channel;
        cand = 32'h00000000;
        found = 1'b0;
        for (i = 1; i <= NCH; i = i + 1)
        begin
            // Candidate index wraps modulo the channel count
            cand = (scan_channel + i) % NCH;
            if (!found && enabled[cand])
            begin
                next_ch = cand[CW-1:0];
                found = 1'b1;
            end
        end
    end

    always @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            slot_cnt_q <= 16'h0000;
            scan_channel <= {CW{1'b0}};
            scan_kind <= `MSSA_KIND_DEFAULT;
            scan_start <= 1'b0;
        end
        else if (clk_en)
        begin
            scan_start <= 1'b0;
            if (slot_cnt_q == SLOT_CYCLES - 1)
            begin
                slot_cnt_q <= 16'h0000;
                // With every channel disabled the slot passes idle
                if (found)
                begin
                    scan_channel <= next_ch;
                    scan_kind <= kind_q[next_ch];
                    scan_start <= 1'b1;
                end
            end
            else
                slot_cnt_q <= slot_cnt_q + 16'h0001;
        end
    end

    mssa_smooth #(
        .DW(DW),
        .KW(`MSSA_WEIGHT_W)
    ) u_smooth (
        .raw_sample(sample_q),
        .prev_out(data_q[scan_channel]),
        .weight(weight_q[scan_channel]),
        .filt_out(filt_out)
    );

    assign stored_value = open_q ?
        (fail_pos_q[scan_channel] ? `MSSA_DATA_OPEN_HIGH : `MSSA_DATA_OPEN_LOW) : filt_out;

    // Per-channel configuration and data store
    generate
        for (g = 0; g < NCH; g = g + 1)
        begin : g_ch
            assign enabled[g] = kind_q[g] != `MSSA_KIND_DISABLED;
            always @(posedge clk_sys or negedge reset_n)
            begin
                if (!reset_n)
                begin
                    kind_q[g] <= `MSSA_KIND_DEFAULT;
                    weight_q[g] <= `MSSA_WEIGHT_RESET;
                    data_q[g] <= {DW{1'b0}};
                    fail_pos_q[g] <= `MSSA_FAIL_RESET;
                    fresh_q[g] <= 1'b0;
                    // Limits are left at zero; software must treat them as undefined
                    upper_q[g] <= {DW{1'b0}};
                    lower_q[g] <= {DW{1'b0}};
                end
                else if (clk_en)
                begin
                    if (declare_sensor_kind && cmd_channel == g)
                    begin
                        kind_q[g] <= kind_eff;
                        data_q[g] <= {DW{1'b0}};
                        weight_q[g] <= `MSSA_WEIGHT_RESET;
                        // Stale zero after a declare must not trip an armed alarm
                        fresh_q[g] <= 1'b0;
                    end
                    else
                    begin
                        if (set_smoothing && cmd_channel == g)
                            weight_q[g] <= smoothing_weight;
                        if (store_q && scan_channel == g && enabled[g])
                        begin
                            data_q[g] <= stored_value;
                            fresh_q[g] <= 1'b1;
                        end
                    end
                    if (set_open_sensor_direction && cmd_channel == g)
                        fail_pos_q[g] <= fail_positive;
                    if (set_limit_pair && cmd_channel == g)
                    begin
                        upper_q[g] <= upper_threshold;
                        lower_q[g] <= lower_threshold;
                    end
                end
            end
            mssa_alarm #(
                .DW(DW)
            ) u_alarm (
                .clk_sys(clk_sys),
                .reset_n(reset_n),
                .clk_en(clk_en),
                .arm_cmd(arm_or_disarm_limit && cmd_channel == g),
                .arm_value(arm_value),
                .kind_cmd(declare_sensor_kind && cmd_channel == g),
                .alarm_read(read_and_clear_alarm_states),
                .sample_valid(fresh_q[g] && enabled[g]),
                .data_value(data_q[g]),
                .upper_threshold(upper_q[g]),
                .lower_threshold(lower_q[g]),
                .sounding(sounding[g]),
                .armed()
            );
        end
    endgenerate

    // Read answers, registered one cycle after the request
    always @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            read_data <= {DW{1'b0}};
            read_valid <= 1'b0;
            all_data <= {NCH*DW{1'b0}};
            alarm_status <= {NCH{1'b0}};
            alarm_summary <= 1'b0;
        end
        else if (clk_en)
        begin
            read_valid <= read_one_channel || read_every_channel ||
                          read_junction_temperature || read_and_clear_alarm_states;
            if (read_one_channel)
                read_data <= data_q[cmd_channel];
            else if (read_junction_temperature)
                read_data <= jt_val_q;
            // Own loop index, so the scan search stays the only writer of i
            if (read_every_channel)
                for (j = 0; j < NCH; j = j + 1)
                    all_data[j*DW +: DW] <= data_q[j];
            if (read_and_clear_alarm_states)
            begin
                alarm_status <= sounding;
                alarm_summary <= |sounding;
            end
        end
    end
endmodule

// ==== bench/mssa_asserts.sv ====
// Port-level assertions for the scan and alarm block
`timescale 1ns/100ps
module mssa_asserts #(
    parameter NCH = 8,
    parameter CW = 3,
    parameter DW = 16,
    parameter SLOT_CYCLES = 8
) (
    input wire clk_sys,
    input wire reset_n,
    input wire clk_en,
    input wire declare_sensor_kind,
    input wire arm_or_disarm_limit,
    input wire read_one_channel,
    input wire read_every_channel,
    input wire read_junction_temperature,
    input wire read_and_clear_alarm_states,
    input wire [CW-1:0] scan_channel,
    input wire [7:0] scan_kind,
    input wire scan_start,
    input wire read_valid,
    input wire [NCH-1:0] alarm_status,
    input wire alarm_summary,
    input wire board_alarm
);
    wire any_rd = read_one_channel | read_every_channel | read_junction_temperature | read_and_clear_alarm_states;
    reg [15:0] gap_q;
    reg seen_q;
    // Slot spacing counted here; a repetition would not scale with the slot length
    always @(posedge clk_sys or negedge reset_n)
        if (!reset_n)
        begin
            gap_q <= 16'h0000;
            seen_q <= 1'b0;
        end
        else if (clk_en)
        begin
            gap_q <= scan_start ? 16'h0001 : gap_q + 16'h0001;
            seen_q <= seen_q | scan_start;
        end
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!reset_n);
    property p_rd_answer;
        clk_en && read_one_channel |=> read_valid;
    endproperty
    a_rd_answer: assert property (p_rd_answer) else $error("no read_valid after read");
    property p_rd_cause;
        read_valid |-> $past(any_rd);
    endproperty
    a_rd_cause: assert property (p_rd_cause) else $error("read_valid without read");
    property p_slot;
        scan_start && seen_q |-> gap_q == SLOT_CYCLES;
    endproperty
    a_slot: assert property (p_slot) else $error("scan start spacing wrong");
    property p_chan_hold;
        !scan_start |-> $stable(scan_channel);
    endproperty
    a_chan_hold: assert property (p_chan_hold) else $error("scan channel moved mid slot");
    property p_kind;
        scan_start |-> scan_kind <= 8'h0F;
    endproperty
    a_kind: assert property (p_kind) else $error("bad kind scanned");
    property p_summary;
        clk_en && read_and_clear_alarm_states |=> alarm_summary == (|alarm_status);
    endproperty
    a_summary: assert property (p_summary) else $error("summary disagrees with status");
    property p_summary_src;
        clk_en && read_and_clear_alarm_states |=> alarm_summary == $past(board_alarm);
    endproperty
    a_summary_src: assert property (p_summary_src) else $error("summary not board alarm");
    property p_hold;
        board_alarm && !read_and_clear_alarm_states && !declare_sensor_kind && !arm_or_disarm_limit |=> board_alarm;
    endproperty
    a_hold: assert property (p_hold) else $error("sounding dropped early");
endmodule
bind mssa_scan_top mssa_asserts #(.NCH(NCH), .CW(CW), .DW(DW), .SLOT_CYCLES(SLOT_CYCLES)) chk_u (.*);

// ==== bench/mssa_adc_model.sv ====
// Behavioural converter that answers each scan request
`timescale 1ns/100ps
module mssa_adc_model (
    input wire clk_sys,
    input wire scan_start,
    input wire [2:0] scan_channel,
    input wire [15:0] level,
    input wire [7:0] open_mask,
    output reg [15:0] adc_sample = 16'h0000,
    output reg adc_open_sensor = 1'b0,
    output reg adc_done = 1'b0
);
    integer t = 99;
    always @(posedge clk_sys)
    begin
        t = scan_start ? 0 : t + 1;
        adc_done <= t >= 2 && t < 5;
        if (t == 0)
        begin
            adc_sample <= level;
            adc_open_sensor <= open_mask[scan_channel];
        end
        else if (t >= 12)
        begin
            // Released lines keep moving so stale data cannot pass for fresh
            adc_sample <= ~adc_sample;
            adc_open_sensor <= ~adc_open_sensor;
        end
    end
endmodule

// ==== bench/multichannel_sensor_scan_alarm_tb.sv ====
// Self-checking bench for the scan and alarm block
`timescale 1ns/100ps
module multichannel_sensor_scan_alarm_tb;
    localparam DCL = 9'h100, SMO = 9'h080, DIR = 9'h040, LIM = 9'h020, ARM = 9'h010;
    localparam RD1 = 9'h008, RDA = 9'h004, RDJ = 9'h002, RDC = 9'h001;
    reg clk_sys = 0, reset_n = 0, clk_en = 1, arm_value = 0, fail_positive = 1;
    reg [8:0] stb = 0;
    wire declare_sensor_kind = stb[8], set_smoothing = stb[7], set_open_sensor_direction = stb[6];
    wire set_limit_pair = stb[5], arm_or_disarm_limit = stb[4], read_one_channel = stb[3];
    wire read_every_channel = stb[2], read_junction_temperature = stb[1], read_and_clear_alarm_states = stb[0];
    reg [2:0] cmd_channel = 0;
    reg [7:0] sensor_kind_code = 0, smoothing_weight = 0, open_mask = 0;
    reg [15:0] upper_threshold = 0, lower_threshold = 0, level = 16'h0100, junction_temp_pin = 16'h1234;
    wire [15:0] adc_sample, read_data;
    wire adc_open_sensor, adc_done, scan_start, read_valid, alarm_summary, board_alarm;
    wire [2:0] scan_channel;
    wire [7:0] scan_kind, alarm_status;
    wire [127:0] all_data;
    integer fails = 0, samples_checked = 0, i, e;
    always #4 clk_sys = ~clk_sys;
    mssa_scan_top #(.SLOT_CYCLES(16)) dut_u (.*);
    mssa_adc_model adc_u (.*);
    task chk(input string nm, input [127:0] ex, input [127:0] sn);
    begin
        samples_checked = samples_checked + 1;
        if (sn !== ex)
        begin
            fails = fails + 1;
            $display("BAD %s expected %h seen %h", nm, ex, sn);
        end
    end
    endtask
    task tick(input integer n);
        repeat (n) @(negedge clk_sys);
    endtask
    // Ends on the negedge where read results stand
    task cmd(input [8:0] s, input [2:0] ch);
    begin
        tick(1);
        stb = s;
        cmd_channel = ch;
        tick(1);
        stb = 0;
    end
    endtask
    task rd(input [2:0] ch, input [15:0] ex);
    begin
        cmd(RD1, ch);
        chk("read_data", ex, read_data);
    end
    endtask
    task wait_start(input integer ch);
    begin
        e = 0;
        tick(1);
        while (!(scan_start === 1'b1 && (ch < 0 || scan_channel === ch[2:0])) && e < 400)
        begin
            tick(1);
            e = e + 1;
        end
        if (e >= 400)
            chk("scan_start", 1, 0);
    end
    endtask
    task test_done;
    begin
        $display("checks %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    end
    endtask
    initial
    begin
        tick(10);
        reset_n = 1;
        chk("scan_kind", 8'h00, scan_kind);
        chk("board_alarm", 0, board_alarm);
        cmd(RDA, 0);
        chk("all_data", 0, all_data);
        tick(2);
        cmd(RDJ, 0);
        chk("junction", 16'h1234, read_data);
        $display("test reset done");
        tick(300);
        rd(0, 16'h0100);
        open_mask = 8'h04;
        tick(300);
        rd(2, 16'h7FFF);
        fail_positive = 0;
        cmd(DIR, 2);
        tick(300);
        rd(2, 16'h8001);
        open_mask = 0;
        $display("test open sensor done");
        wait_start(1);
        smoothing_weight = 8'h40;
        level = 16'h0500;
        cmd(SMO, 1);
        tick(12);
        rd(1, 16'h0400);
        wait_start(1);
        tick(12);
        rd(1, 16'h04C0);
        sensor_kind_code = 8'h01;
        cmd(DCL, 1);
        rd(1, 16'h0000);
        tick(160);
        rd(1, 16'h0500);
        $display("test smoothing done");
        sensor_kind_code = 8'h05;
        cmd(DCL, 5);
        sensor_kind_code = 8'h20;
        cmd(DCL, 6);
        sensor_kind_code = 8'hFF;
        cmd(DCL, 3);
        wait_start(-1);
        wait_start(-1);
        i = scan_channel;
        repeat (10)
        begin
            wait_start(-1);
            i = (i + 1) % 8;
            if (i == 3)
                i = 4;
            chk("scan_channel", i, scan_channel);
            chk("scan_kind", i == 5 ? 8'h05 : (i == 1 ? 8'h01 : 8'h00), scan_kind);
        end
        clk_en = 0;
        i = scan_channel;
        tick(40);
        chk("scan_channel", i, scan_channel);
        clk_en = 1;
        $display("test scan done");
        upper_threshold = 16'h1000;
        lower_threshold = 16'h0000;
        cmd(LIM, 0);
        arm_value = 1;
        cmd(ARM, 0);
        tick(300);
        chk("board_alarm", 0, board_alarm);
        level = 16'h2000;
        tick(300);
        chk("board_alarm", 1, board_alarm);
        cmd(RDC, 0);
        chk("alarm_status", 8'h01, alarm_status);
        chk("alarm_summary", 1, alarm_summary);
        chk("board_alarm", 0, board_alarm);
        tick(300);
        chk("board_alarm", 0, board_alarm);
        level = 16'h0500;
        tick(300);
        cmd(ARM, 0);
        cmd(LIM, 7);
        cmd(ARM, 7);
        arm_value = 0;
        cmd(ARM, 0);
        sensor_kind_code = 8'h00;
        cmd(DCL, 7);
        level = 16'h2000;
        tick(300);
        chk("board_alarm", 0, board_alarm);
        upper_threshold = 16'h0100;
        lower_threshold = 16'h0200;
        cmd(LIM, 4);
        arm_value = 1;
        cmd(ARM, 4);
        tick(2);
        chk("board_alarm", 1, board_alarm);
        cmd(RDC, 0);
        chk("alarm_status", 8'h10, alarm_status);
        $display("test alarm done");
        test_done;
    end
    initial
    begin
        #(8 * 10000);
        fails = fails + 1;
        test_done;
    end
endmodule
